//--- io_space_pkg.sv
// ==================================================================
// shared constants of the i/o register space
// ==================================================================
package io_space_pkg;

    // ==============================================================
    // address map
    // ==============================================================
    localparam logic [7:0] IO_DS_OFFSET     = 8'h20;
    localparam logic [7:0] EXT_BASE         = 8'h60;
    localparam logic [4:0] FLAG_IO_ADDR     = 5'h17;
    localparam logic [4:0] SCRATCH_IO_ADDR  = 5'h1e;
    localparam logic [7:0] T2_CTRL_A_ADDR   = 8'hb0;
    localparam logic [7:0] T2_CTRL_B_ADDR   = 8'hb1;
    localparam logic [7:0] T2_COUNT_ADDR    = 8'hb2;
    localparam logic [7:0] T2_CMP_A_ADDR    = 8'hb3;
    localparam logic [7:0] T2_CMP_B_ADDR    = 8'hb4;

    // ==============================================================
    // field layouts
    // ==============================================================
    localparam logic [7:0] FLAG_W1C_MASK    = 8'h07;
    localparam logic [7:0] SCRATCH_W1C_MASK = 8'h00;
    localparam logic [7:0] T2_CTRL_A_MASK   = 8'hf3;
    localparam logic [7:0] T2_CTRL_B_MASK   = 8'h0f;
    localparam int         T2_FORCE_A_BIT   = 7;
    localparam int         T2_FORCE_B_BIT   = 6;
    localparam int         FLAG_COUNT       = 3;

    // ==============================================================
    // values after reset
    // ==============================================================
    localparam logic [7:0] FLAG_RST         = 8'h00;
    localparam logic [7:0] SCRATCH_RST      = 8'h00;
    localparam logic [7:0] T2_REG_RST       = 8'h00;

endpackage

//--- bit_access_reg.sv
`timescale 1ns/1ps
// ==================================================================
// one low-range register with whole and single-bit access
// ==================================================================
module bit_access_reg
#(
    parameter logic [7:0] W1C_MASK = 8'h00,
    parameter logic [7:0] RST_VAL  = 8'h00
)
(
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // whole-register write
    input  wire logic       wr_i,
    input  wire logic [7:0] wr_data_i,
    // single-bit access
    input  wire logic       bit_set_i,
    input  wire logic       bit_clr_i,
    input  wire logic [2:0] bit_sel_i,
    // hardware events
    input  wire logic [7:0] hw_set_i,
    // contents
    output logic      [7:0] value_o
);

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_bit
            logic bit_q;
            logic bit_d;
            logic hit;

            always_comb
            begin
                hit   = (bit_sel_i == 3'(i));
                bit_d = bit_q;
                if (W1C_MASK[i])
                begin
                    // one clears, set from hardware wins
                    if ((wr_i && wr_data_i[i]) || (bit_set_i && hit))
                        bit_d = 1'b0;
                    if (hw_set_i[i])
                        bit_d = 1'b1;
                end
                else
                begin
                    if (wr_i)
                        bit_d = wr_data_i[i];
                    if (bit_set_i && hit)
                        bit_d = 1'b1;
                    if (bit_clr_i && hit)
                        bit_d = 1'b0;
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    bit_q <= RST_VAL[i];
                else if (ce_i)
                    bit_q <= bit_d;
            end

            assign value_o[i] = bit_q;
        end
    endgenerate

endmodule // bit_access_reg

//--- io_register_space_decode.sv
`timescale 1ns/1ps
module io_register_space_decode
(
    // clock, reset, enable
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ce_i,
    // short i/o-port access
    input  wire logic                   io_rd_i,
    input  wire logic                   io_wr_i,
    input  wire logic [5:0]             io_addr_i,
    // data-space access
    input  wire logic                   ds_rd_i,
    input  wire logic                   ds_wr_i,
    input  wire logic [7:0]             ds_addr_i,
    // single-bit access
    input  wire logic                   bit_set_instruction_i,
    input  wire logic                   bit_clear_instruction_i,
    input  wire logic                   skip_if_bit_set_instruction_i,
    input  wire logic                   skip_if_bit_clear_instruction_i,
    input  wire logic [4:0]             bit_addr_i,
    input  wire logic [2:0]             bit_sel_i,
    // write data and events
    input  wire logic [7:0]             wr_data_i,
    input  wire logic [io_space_pkg::FLAG_COUNT-1:0] flag_event_i,
    // answers to the core
    output logic      [7:0]             rd_data_o,
    output logic                        rd_valid_o,
    output logic                        skip_o,
    output logic                        test_valid_o,
    output logic                        access_err_o,
    // register contents
    output logic      [7:0]             flags_o,
    output logic      [7:0]             scratch_o,
    output logic      [7:0]             timer2_control_a_o,
    output logic      [7:0]             timer2_control_b_o,
    output logic      [7:0]             timer2_count_value_o,
    output logic      [7:0]             timer2_compare_a_value_o,
    output logic      [7:0]             timer2_compare_b_value_o,
    output logic                        timer2_force_a_o,
    output logic                        timer2_force_b_o
);
    import io_space_pkg::*;

    // ==============================================================
    // request decode
    // ==============================================================
    logic [2:0] req_cnt;
    logic       one_req;
    logic       any_rd;
    logic       any_wr;
    logic       any_test;
    logic [7:0] ds_a;
    logic       bit_op;
    logic [7:0] flag_val;
    logic [7:0] scratch_val;
    logic [7:0] rd_mux;

    always_comb
    begin
        req_cnt = 3'({2'b00, io_rd_i}) + 3'({2'b00, io_wr_i}) + 3'({2'b00, ds_rd_i})
                + 3'({2'b00, ds_wr_i}) + 3'({2'b00, bit_set_instruction_i})
                + 3'({2'b00, bit_clear_instruction_i})
                + 3'({2'b00, skip_if_bit_set_instruction_i})
                + 3'({2'b00, skip_if_bit_clear_instruction_i});
        one_req  = (req_cnt == 3'd1);
        any_test = skip_if_bit_set_instruction_i || skip_if_bit_clear_instruction_i;
        bit_op   = bit_set_instruction_i || bit_clear_instruction_i || any_test;
        any_rd   = one_req && (io_rd_i || ds_rd_i);
        any_wr   = one_req && (io_wr_i || ds_wr_i);
        // every path ends in one data-space address
        if (ds_rd_i || ds_wr_i)
            ds_a = ds_addr_i;
        else if (bit_op)
            ds_a = {3'b000, bit_addr_i} + IO_DS_OFFSET;
        else
            ds_a = {2'b00, io_addr_i} + IO_DS_OFFSET;
    end

    // ==============================================================
    // low-range bit-accessible registers
    // ==============================================================
    logic flag_hit;
    logic scratch_hit;

    assign flag_hit    = one_req && (ds_a == ({3'b000, FLAG_IO_ADDR} + IO_DS_OFFSET));
    assign scratch_hit = one_req && (ds_a == ({3'b000, SCRATCH_IO_ADDR} + IO_DS_OFFSET));

    bit_access_reg
    #(
        .W1C_MASK (FLAG_W1C_MASK),
        .RST_VAL  (FLAG_RST)
    )
    u_flags
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        // reserved flag bits never take a write or a bit op
        .wr_i      (flag_hit && any_wr),
        .wr_data_i (wr_data_i & FLAG_W1C_MASK),
        .bit_set_i (flag_hit && bit_set_instruction_i && FLAG_W1C_MASK[bit_sel_i]),
        .bit_clr_i (flag_hit && bit_clear_instruction_i && FLAG_W1C_MASK[bit_sel_i]),
        .bit_sel_i (bit_sel_i),
        .hw_set_i  ({{(8-FLAG_COUNT){1'b0}}, flag_event_i}),
        .value_o   (flag_val)
    );

    bit_access_reg
    #(
        .W1C_MASK (SCRATCH_W1C_MASK),
        .RST_VAL  (SCRATCH_RST)
    )
    u_scratch
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .wr_i      (scratch_hit && any_wr),
        .wr_data_i (wr_data_i),
        .bit_set_i (scratch_hit && bit_set_instruction_i),
        .bit_clr_i (scratch_hit && bit_clear_instruction_i),
        .bit_sel_i (bit_sel_i),
        .hw_set_i  (8'h00),
        .value_o   (scratch_val)
    );

    // ==============================================================
    // timer2 register file
    // ==============================================================
    logic [7:0] ctrl_a_q, ctrl_a_d;
    logic [7:0] ctrl_b_q, ctrl_b_d;
    logic [7:0] count_q, count_d;
    logic [7:0] cmp_a_q, cmp_a_d;
    logic [7:0] cmp_b_q, cmp_b_d;
    logic       force_a_q, force_a_d;
    logic       force_b_q, force_b_d;

    always_comb
    begin
        ctrl_a_d  = ctrl_a_q;
        ctrl_b_d  = ctrl_b_q;
        count_d   = count_q;
        cmp_a_d   = cmp_a_q;
        cmp_b_d   = cmp_b_q;
        force_a_d = 1'b0;
        force_b_d = 1'b0;
        // only data-space stores reach here
        if (one_req && ds_wr_i)
        begin
            unique case (ds_addr_i)
                T2_CTRL_A_ADDR: ctrl_a_d = wr_data_i & T2_CTRL_A_MASK;
                T2_CTRL_B_ADDR:
                begin
                    ctrl_b_d  = wr_data_i & T2_CTRL_B_MASK;
                    force_a_d = wr_data_i[T2_FORCE_A_BIT];
                    force_b_d = wr_data_i[T2_FORCE_B_BIT];
                end
                T2_COUNT_ADDR:  count_d = wr_data_i;
                T2_CMP_A_ADDR:  cmp_a_d = wr_data_i;
                T2_CMP_B_ADDR:  cmp_b_d = wr_data_i;
                default:        ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_a_q  <= T2_REG_RST;
            ctrl_b_q  <= T2_REG_RST;
            count_q   <= T2_REG_RST;
            cmp_a_q   <= T2_REG_RST;
            cmp_b_q   <= T2_REG_RST;
            force_a_q <= 1'b0;
            force_b_q <= 1'b0;
        end
        else if (ce_i)
        begin
            ctrl_a_q  <= ctrl_a_d;
            ctrl_b_q  <= ctrl_b_d;
            count_q   <= count_d;
            cmp_a_q   <= cmp_a_d;
            cmp_b_q   <= cmp_b_d;
            force_a_q <= force_a_d;
            force_b_q <= force_b_d;
        end
    end

    // ==============================================================
    // read path and answers
    // ==============================================================
    logic [7:0] rd_data_q, rd_data_d;
    logic       rd_valid_q, rd_valid_d;
    logic       skip_q, skip_d;
    logic       test_valid_q, test_valid_d;
    logic       err_q, err_d;

    always_comb
    begin
        // force strobes and reserved bits read zero
        if (flag_hit)
            rd_mux = flag_val;
        else if (scratch_hit)
            rd_mux = scratch_val;
        else if (ds_a == T2_CTRL_A_ADDR)
            rd_mux = ctrl_a_q;
        else if (ds_a == T2_CTRL_B_ADDR)
            rd_mux = ctrl_b_q;
        else if (ds_a == T2_COUNT_ADDR)
            rd_mux = count_q;
        else if (ds_a == T2_CMP_A_ADDR)
            rd_mux = cmp_a_q;
        else if (ds_a == T2_CMP_B_ADDR)
            rd_mux = cmp_b_q;
        else
            rd_mux = 8'h00;
        rd_data_d    = any_rd ? rd_mux : rd_data_q;
        rd_valid_d   = any_rd;
        test_valid_d = one_req && any_test;
        skip_d       = 1'b0;
        if (one_req && skip_if_bit_set_instruction_i)
            skip_d = rd_mux[bit_sel_i];
        else if (one_req && skip_if_bit_clear_instruction_i)
            skip_d = ~rd_mux[bit_sel_i];
        err_d        = (req_cnt > 3'd1);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_q    <= 8'h00;
            rd_valid_q   <= 1'b0;
            skip_q       <= 1'b0;
            test_valid_q <= 1'b0;
            err_q        <= 1'b0;
        end
        else if (ce_i)
        begin
            rd_data_q    <= rd_data_d;
            rd_valid_q   <= rd_valid_d;
            skip_q       <= skip_d;
            test_valid_q <= test_valid_d;
            err_q        <= err_d;
        end
    end

    assign rd_data_o                = rd_data_q;
    assign rd_valid_o               = rd_valid_q;
    assign skip_o                   = skip_q;
    assign test_valid_o             = test_valid_q;
    assign access_err_o             = err_q;
    assign flags_o                  = flag_val;
    assign scratch_o                = scratch_val;
    assign timer2_control_a_o       = ctrl_a_q;
    assign timer2_control_b_o       = ctrl_b_q;
    assign timer2_count_value_o     = count_q;
    assign timer2_compare_a_value_o = cmp_a_q;
    assign timer2_compare_b_value_o = cmp_b_q;
    assign timer2_force_a_o         = force_a_q;
    assign timer2_force_b_o         = force_b_q;

endmodule // io_register_space_decode

//--- core_model.sv
`timescale 1ns/1ps
// ==========================================
// processor core issuing register accesses
// ==========================================
module core_model
(
    // clock
    input  wire logic       sys_clk_i,
    // requests: in out ld st set clr tset tclr
    output logic      [7:0] req_o,
    output logic      [7:0] addr_o,
    output logic      [2:0] sel_o,
    output logic      [7:0] data_o
);
    initial
    begin
        req_o  = 8'h00;
        addr_o = 8'h00;
        sel_o  = 3'h0;
        data_o = 8'h00;
    end

    // load/store address of an i/o register
    function automatic logic [7:0] ds_alias(input logic [5:0] io);
        return {2'b00, io} + io_space_pkg::IO_DS_OFFSET;
    endfunction

    // one access, taken at one edge, then released
    task automatic access(input logic [7:0] req, input logic [7:0] addr,
                          input logic [2:0] sel, input logic [7:0] data);
        @(posedge sys_clk_i);
        req_o  <= req;
        addr_o <= addr;
        sel_o  <= sel;
        data_o <= data;
        @(posedge sys_clk_i);
        req_o  <= 8'h00;
        // released lines must not keep the old value
        addr_o <= ~addr;
        sel_o  <= ~sel;
        data_o <= ~data;
        #1;
    endtask
endmodule // core_model

//--- io_space_sva.sv
`timescale 1ns/1ps
// ==========================================
// checks on the register space ports
// ==========================================
module io_space_sva
(
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    input wire logic       ce_i,
    input wire logic       io_rd_i,
    input wire logic       io_wr_i,
    input wire logic [5:0] io_addr_i,
    input wire logic       ds_rd_i,
    input wire logic       ds_wr_i,
    input wire logic [7:0] ds_addr_i,
    input wire logic       bit_set_instruction_i,
    input wire logic       bit_clear_instruction_i,
    input wire logic       skip_if_bit_set_instruction_i,
    input wire logic       skip_if_bit_clear_instruction_i,
    input wire logic [4:0] bit_addr_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [2:0] flag_event_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       rd_valid_o,
    input wire logic       skip_o,
    input wire logic       test_valid_o,
    input wire logic [7:0] flags_o,
    input wire logic [7:0] scratch_o,
    input wire logic [7:0] timer2_control_b_o,
    input wire logic       timer2_force_a_o
);
    import io_space_pkg::*;
    localparam logic [7:0] SCR_DS = {3'h0, SCRATCH_IO_ADDR} + IO_DS_OFFSET;
    logic one_req;
    logic scr_bit;
    logic flag_bit;
    assign one_req = ce_i && $onehot({io_rd_i, io_wr_i, ds_rd_i, ds_wr_i,
        bit_set_instruction_i, bit_clear_instruction_i,
        skip_if_bit_set_instruction_i, skip_if_bit_clear_instruction_i});
    assign scr_bit = one_req && bit_addr_i == SCRATCH_IO_ADDR;
    assign flag_bit = one_req && bit_addr_i == FLAG_IO_ADDR && flag_event_i == 3'h0;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_rd_req;
        one_req && (ds_rd_i || io_rd_i);
    endsequence
    sequence s_rd_ans;
        rd_valid_o && !test_valid_o;
    endsequence

    a_read_answer: assert property (s_rd_req |=> s_rd_ans)
        else $error("read not answered next cycle");
    a_scratch_alias: assert property (one_req && ds_rd_i && ds_addr_i == SCR_DS
        |=> rd_data_o == $past(scratch_o)) else $error("load alias read wrong");
    a_test_set: assert property (scr_bit && skip_if_bit_set_instruction_i |=>
        test_valid_o && (($past(scratch_o) >> $past(bit_sel_i)) & 8'h01) == {7'h0, skip_o})
        else $error("bit test result wrong");
    a_bit_set: assert property (scr_bit && bit_set_instruction_i |=>
        scratch_o == ($past(scratch_o) | (8'h01 << $past(bit_sel_i))))
        else $error("bit set wrong");
    a_bit_clear: assert property (scr_bit && bit_clear_instruction_i |=>
        scratch_o == ($past(scratch_o) & ~(8'h01 << $past(bit_sel_i))))
        else $error("bit clear wrong");
    a_flag_w1c: assert property (one_req && io_wr_i && flag_event_i == 3'h0
        && io_addr_i == {1'b0, FLAG_IO_ADDR} |=> (flags_o & $past(wr_data_i)) == 8'h00)
        else $error("flag not cleared by one");
    a_flag_bit_only: assert property (flag_bit && bit_set_instruction_i |=>
        flags_o == ($past(flags_o) & ~(8'h01 << $past(bit_sel_i))))
        else $error("flag bit op touched others");
    a_reserved_bits: assert property (flags_o[7:3] == 5'h0
        && timer2_control_b_o[7:4] == 4'h0) else $error("reserved bit set");
    a_reserved_read: assert property (one_req && ds_rd_i
        && ds_addr_i inside {[8'h8f:8'haf]} |=> rd_data_o == 8'h00)
        else $error("reserved read not zero");
    a_timer_io: assert property (one_req && io_wr_i |=> $stable(timer2_control_b_o))
        else $error("timer reached by out");
    a_timer_store: assert property (one_req && ds_wr_i && ds_addr_i == T2_CTRL_B_ADDR
        |=> timer2_control_b_o == ($past(wr_data_i) & T2_CTRL_B_MASK)
        && timer2_force_a_o == ($past(wr_data_i) > 8'h7f)) else $error("timer store wrong");
endmodule // io_space_sva

bind io_register_space_decode io_space_sva io_space_sva_inst (.*);

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import io_space_pkg::*;
    localparam logic [7:0] IR = 8'h80, IW = 8'h40, DR = 8'h20, DW = 8'h10;
    localparam logic [7:0] BS = 8'h08, BC = 8'h04, TS = 8'h02, TC = 8'h01;
    logic sys_clk_i, rst_n_i, ce_i, rd_valid_o, skip_o, test_valid_o, access_err_o;
    logic io_rd_i, io_wr_i, ds_rd_i, ds_wr_i, bit_set_instruction_i;
    logic bit_clear_instruction_i, skip_if_bit_set_instruction_i;
    logic skip_if_bit_clear_instruction_i, timer2_force_a_o, timer2_force_b_o;
    logic [7:0] req, addr, ds_addr_i, wr_data_i, rd_data_o, flags_o, scratch_o;
    logic [7:0] timer2_control_a_o, timer2_control_b_o, timer2_count_value_o;
    logic [7:0] timer2_compare_a_value_o, timer2_compare_b_value_o;
    logic [5:0] io_addr_i;
    logic [4:0] bit_addr_i;
    logic [2:0] sel, bit_sel_i, flag_event_i;
    logic [7:0] t2_exp [5] = '{8'hf3, 8'h0f, 8'hff, 8'hff, 8'hff};
    int err_count = 0, compares = 0, cycles = 0;

    assign {io_rd_i, io_wr_i, ds_rd_i, ds_wr_i, bit_set_instruction_i, bit_clear_instruction_i,
        skip_if_bit_set_instruction_i, skip_if_bit_clear_instruction_i} = req;
    assign io_addr_i = addr[5:0];
    assign ds_addr_i = addr;
    assign bit_addr_i = addr[4:0];
    assign bit_sel_i = sel;

    core_model core_model_inst (.sys_clk_i(sys_clk_i), .req_o(req), .addr_o(addr),
        .sel_o(sel), .data_o(wr_data_i));
    io_register_space_decode io_register_space_decode_inst (.*);

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] k, input logic [7:0] a, input logic [2:0] s,
                      input logic [7:0] d);
        core_model_inst.access(k, a, s, d);
    endtask
    task automatic rd_chk(input logic [7:0] k, input logic [7:0] a, input logic [7:0] e);
        core_model_inst.access(k, a, 3'h0, 8'h00);
        chk("rd_valid", 8'h01, {7'h0, rd_valid_o});
        chk("rd_data", e, rd_data_o);
    endtask
    task automatic tst(input logic [7:0] k, input logic [2:0] s, input logic e);
        core_model_inst.access(k, {3'h0, SCRATCH_IO_ADDR}, s, 8'h00);
        chk("skip", {6'h0, 1'b1, e}, {6'h0, test_valid_o, skip_o});
    endtask
    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 500)
        begin
            err_count++;
            wrap_up();
        end
    end

    initial
    begin
        rst_n_i = 1'b0;
        ce_i = 1'b0;
        flag_event_i = 3'h0;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        ce_i <= 1'b1;
        #1;
        chk("scratch", SCRATCH_RST, scratch_o);
        chk("flags", FLAG_RST, flags_o);
        wr(IW, 8'h1e, 3'h0, 8'ha5);
        rd_chk(DR, core_model_inst.ds_alias(6'h1e), 8'ha5);
        rd_chk(IR, 8'h1e, 8'ha5);
        wr(BS, 8'h1e, 3'h1, 8'h00);
        chk("scratch", 8'ha7, scratch_o);
        wr(BC, 8'h1e, 3'h7, 8'h00);
        chk("scratch", 8'h27, scratch_o);
        tst(TS, 3'h0, 1'b1);
        tst(TC, 3'h3, 1'b1);
        tst(TS, 3'h3, 1'b0);
        core_model_inst.access(IW | BS, 8'h1e, 3'h0, 8'h00);
        chk("access_err", 8'h01, {7'h0, access_err_o});
        chk("scratch", 8'h27, scratch_o);
        // raise all three status flags
        @(posedge sys_clk_i) flag_event_i <= 3'h7;
        @(posedge sys_clk_i) flag_event_i <= 3'h0;
        wr(BS, {3'h0, FLAG_IO_ADDR}, 3'h1, 8'h00);
        chk("flags", 8'h05, flags_o);
        wr(DW, core_model_inst.ds_alias(6'h17), 3'h0, 8'h04);
        chk("flags", 8'h01, flags_o);
        wr(IW, {3'h0, FLAG_IO_ADDR}, 3'h0, 8'hff);
        chk("flags", 8'h00, flags_o);
        wr(BS, {3'h0, FLAG_IO_ADDR}, 3'h6, 8'h00);
        chk("flags", 8'h00, flags_o);
        for (int i = 0; i < 5; i++)
        begin
            wr(DW, T2_CTRL_A_ADDR + 8'(i), 3'h0, 8'hff);
            chk("force", {6'h0, {2{i == 1}}}, {6'h0, timer2_force_a_o, timer2_force_b_o});
        end
        chk("t2_ctrl_a", 8'hf3, timer2_control_a_o);
        chk("t2_ctrl_b", 8'h0f, timer2_control_b_o);
        chk("t2_cmp_a", 8'hff, timer2_compare_a_value_o);
        chk("t2_cmp_b", 8'hff, timer2_compare_b_value_o);
        for (int i = 0; i < 5; i++)
            rd_chk(DR, T2_CTRL_A_ADDR + 8'(i), t2_exp[i]);
        wr(IW, 8'h30, 3'h0, 8'h00);
        chk("t2_count", 8'hff, timer2_count_value_o);
        rd_chk(IR, 8'h3f, 8'h00);
        wr(DW, 8'h8f, 3'h0, 8'hff);
        wr(DW, 8'haf, 3'h0, 8'hff);
        rd_chk(DR, 8'h8f, 8'h00);
        rd_chk(DR, 8'haf, 8'h00);
        rd_chk(DR, 8'h1e, 8'h00);
        wrap_up();
    end
endmodule // tb
